// [hw/ocs_map.svh]
// constants for the output channel supervisor: sizes, encodings, reset values, timing
// assumes a 20 MHz core clock and eight output channels
// What this block does
// - with short detection enabled, any load short raises one unit-wide error
// - with short detection disabled, load shorts never raise an error
// - automatic restart clears the short error once the short disappears
// - manual restart keeps the short error until short detection is disabled or the next power-up reset
// - fault and idle output settings apply only under handheld priority
// - each channel counts how often its output is switched on
// - with counter check enabled, count above threshold raises a channel error
// - threshold setting 1 to 65000 means that many thousand operations
// - each channel count is written to non-volatile storage once per hour
// - after power-up each count resumes from its last saved value
`ifndef OCS_MAP_SVH
`define OCS_MAP_SVH

`define OCS_NUM_CH        8
`define OCS_CH_W          3
`define OCS_CNT_W         32
`define OCS_THR_W         16
`define OCS_MODE_W        2
`define OCS_TMR_W         40

// output mode encodings, clear is the default
`define OCS_MODE_CLEAR    2'h0
`define OCS_MODE_HOLD     2'h1
`define OCS_MODE_FORCE    2'h2

// threshold range and scale (1 .. 65000, times 1000)
`define OCS_THR_MIN       16'h0001
`define OCS_THR_MAX       16'hfde8
`define OCS_THR_SCALE     32'h0000_03e8

// reset values
`define OCS_RST_DRIVE     8'h00
`define OCS_RST_COUNT     32'h0000_0000

// save period in seconds (3600) and clock rate in hertz (20e6)
`define OCS_SAVE_PERIOD_S 64'h0000_0000_0000_0e10
`define OCS_CLK_HZ        64'h0000_0000_0131_2d00
`define OCS_SAVE_CYCLES   (`OCS_SAVE_PERIOD_S * `OCS_CLK_HZ)

`endif

// [hw/ocs_pkg.sv]
// types shared by the output channel supervisor modules
// assumes ocs_map.svh is on the include path
`include "ocs_map.svh"

package ocs_pkg;

  typedef enum logic [1:0] {
    OCS_SEQ_RESTORE = 2'b00,
    OCS_SEQ_RUN     = 2'b01,
    OCS_SEQ_SAVE    = 2'b10
  } ocs_seq_t;

  // state of the top module
  typedef struct packed {
    ocs_seq_t                  seq;
    logic [`OCS_CH_W-1:0]      ch;
    logic [`OCS_TMR_W-1:0]     tmr;
    logic [`OCS_NUM_CH-1:0]    drive;
    logic [`OCS_NUM_CH-1:0]    forced;
    logic                      short_err;
    logic [`OCS_NUM_CH-1:0]    open_err;
    logic [`OCS_CNT_W-1:0]     nv_data;
  } ocs_top_t;

  // state of one channel counter
  typedef struct packed {
    logic [`OCS_CNT_W-1:0]     count;
    logic                      err;
  } ocs_cnt_t;

endpackage

// [hw/ocs_cnt_if.sv]
// carrier between the sequencer and one channel counter
// assumes both ends share core_clk
`timescale 1ns/10ps
`include "ocs_map.svh"

interface ocs_cnt_if;
  logic                    on_pulse;
  logic                    load;
  logic [`OCS_CNT_W-1:0]   load_value;
  logic                    check_en;
  logic [`OCS_THR_W-1:0]   threshold;
  logic [`OCS_CNT_W-1:0]   count;
  logic                    error;

  modport ctl (output on_pulse, load, load_value, check_en, threshold, input count, error);
  modport cnt (input on_pulse, load, load_value, check_en, threshold, output count, error);
endinterface

// [hw/ocs_sync.sv]
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to core_clk
`timescale 1ns/10ps

module ocs_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ocs_sync_st_t;

  ocs_sync_st_t s_q;
  ocs_sync_st_t s_d;

  // meta feeds only the second stage
  always_comb begin
    s_d.meta   = pin_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;
endmodule // ocs_sync

// [hw/ocs_chan_counter.sv]
// on-operation counter for one output channel with threshold error
// assumes the sequencer drives the ctl end of the carrier
`timescale 1ns/10ps
`include "ocs_map.svh"

module ocs_chan_counter
  import ocs_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  reset,
  input  wire logic  clk_en,
  ocs_cnt_if.cnt     cif
);
  ocs_cnt_t               s_q;
  ocs_cnt_t               s_d;
  logic [`OCS_THR_W-1:0]  thr_c;
  logic [`OCS_CNT_W-1:0]  limit;

  // out-of-range settings are clamped rather than disabling the check
  always_comb begin
    if (cif.threshold < `OCS_THR_MIN) begin
      thr_c = `OCS_THR_MIN;
    end else if (cif.threshold > `OCS_THR_MAX) begin
      thr_c = `OCS_THR_MAX;
    end else begin
      thr_c = cif.threshold;
    end
    limit = `OCS_CNT_W'(thr_c) * `OCS_THR_SCALE;
  end

  // restore load beats counting; count saturates instead of wrapping
  always_comb begin
    s_d = s_q;
    if (cif.load) begin
      s_d.count = cif.load_value;
    end else if (cif.on_pulse && (s_q.count != '1)) begin
      s_d.count = s_q.count + `OCS_CNT_W'(1);
    end
    s_d.err = cif.check_en && (s_q.count > limit);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{count: `OCS_RST_COUNT, err: 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign cif.count = s_q.count;
  assign cif.error = s_q.err;
endmodule // ocs_chan_counter

// [hw/ocs_supervisor.sv]
// output channel supervisor: output mode selection, short and open
// error reporting, per-channel operation counters with hourly save
// and power-up restore through a simple non-volatile store port
// assumes reset is the power-up reset; comm status and commands are on core_clk,
// sense inputs are asynchronous pins; the store answers each request with a pulse
`timescale 1ns/10ps
`include "ocs_map.svh"

module ocs_supervisor
  import ocs_pkg::*;
#(
  parameter logic [`OCS_TMR_W-1:0] SAVE_CYCLES = `OCS_TMR_W'(`OCS_SAVE_CYCLES)
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire logic                              clk_en,
  // configuration
  input  wire logic                              load_short_detect_enable,
  input  wire logic                              short_error_restart_mode,
  input  wire logic [`OCS_NUM_CH-1:0]            open_load_detect_enable,
  input  wire logic [`OCS_NUM_CH*`OCS_MODE_W-1:0] comm_fault_output_mode,
  input  wire logic [`OCS_NUM_CH*`OCS_MODE_W-1:0] comm_idle_output_mode,
  input  wire logic                              handheld_priority,
  input  wire logic [`OCS_NUM_CH-1:0]            counter_check_enable,
  input  wire logic [`OCS_NUM_CH*`OCS_THR_W-1:0] counter_threshold,
  // communication status and master output image
  input  wire logic                              comm_fault,
  input  wire logic                              comm_idle,
  input  wire logic [`OCS_NUM_CH-1:0]            out_command,
  // load sensing pins
  input  wire logic                              short_sense,
  input  wire logic [`OCS_NUM_CH-1:0]            open_sense,
  // non-volatile store
  output logic                                   nv_rd_req,
  output logic      [`OCS_CH_W-1:0]              nv_rd_ch,
  input  wire logic                              nv_rd_valid,
  input  wire logic [`OCS_CNT_W-1:0]             nv_rd_data,
  output logic                                   nv_wr_req,
  output logic      [`OCS_CH_W-1:0]              nv_wr_ch,
  output logic      [`OCS_CNT_W-1:0]             nv_wr_data,
  input  wire logic                              nv_wr_ack,
  // outputs and status
  output logic      [`OCS_NUM_CH-1:0]            drive_out,
  output logic      [`OCS_NUM_CH-1:0]            drive_on_forced,
  output logic                                   short_error,
  output logic      [`OCS_NUM_CH-1:0]            open_error,
  output logic      [`OCS_NUM_CH-1:0]            count_error,
  output logic                                   restore_done
);

  ocs_top_t                       s_q;
  ocs_top_t                       s_d;
  logic                           short_now;
  logic [`OCS_NUM_CH-1:0]         open_now;
  logic [`OCS_NUM_CH-1:0]         on_vec;
  logic [`OCS_NUM_CH-1:0]         load_vec;
  logic [`OCS_NUM_CH-1:0]         err_vec;
  logic [`OCS_CNT_W-1:0]          cnt_vec [`OCS_NUM_CH];
  logic                           use_fault;
  logic                           use_idle;
  logic                           last_ch;
  logic [`OCS_CH_W-1:0]           next_ch;

  // sense pins cross into core_clk before anything looks at them
  ocs_sync #(
    .W (`OCS_NUM_CH + 1)
  ) u_sense_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   ({short_sense, open_sense}),
    .sync_out ({short_now, open_now})
  );

  // one counter per channel, joined through its own carrier
  ocs_cnt_if cif [`OCS_NUM_CH] ();

  generate
    for (genvar i = 0; i < `OCS_NUM_CH; i++) begin : g_ch
      assign cif[i].on_pulse   = on_vec[i];
      assign cif[i].load       = load_vec[i];
      assign cif[i].load_value = nv_rd_data;
      assign cif[i].check_en   = counter_check_enable[i];
      assign cif[i].threshold  = counter_threshold[i*`OCS_THR_W +: `OCS_THR_W];
      assign cnt_vec[i]        = cif[i].count;
      assign err_vec[i]        = cif[i].error;

      ocs_chan_counter u_cnt (
        .core_clk (core_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .cif      (cif[i])
      );
    end
  endgenerate

  // resolve a channel's mode against its present and held state
  function automatic logic mode_level(
    input logic [`OCS_MODE_W-1:0] mode,
    input logic                   held
  );
    logic lvl;
    case (mode)
      `OCS_MODE_HOLD:  lvl = held;
      `OCS_MODE_FORCE: lvl = 1'b1;
      default:         lvl = 1'b0; // clear, and the unused code
    endcase
    return lvl;
  endfunction

  // fault outranks idle when both are reported at once
  always_comb begin
    use_fault = handheld_priority && comm_fault;
    use_idle  = handheld_priority && !comm_fault && comm_idle;
  end

  // channel walk helpers for restore and save
  always_comb begin
    last_ch = (s_q.ch == `OCS_CH_W'(`OCS_NUM_CH - 1));
    next_ch = s_q.ch + `OCS_CH_W'(1);
  end

  // main next-state logic
  always_comb begin
    s_d      = s_q;
    on_vec   = '0;
    load_vec = '0;

    // output selection; outputs stay off until counts are restored
    for (int i = 0; i < `OCS_NUM_CH; i++) begin
      if (s_q.seq == OCS_SEQ_RESTORE) begin
        s_d.drive[i]  = 1'b0;
        s_d.forced[i] = 1'b0;
      end else if (use_fault) begin
        s_d.drive[i]  = mode_level(comm_fault_output_mode[i*`OCS_MODE_W +: `OCS_MODE_W],
                                   s_q.drive[i]);
        s_d.forced[i] = (comm_fault_output_mode[i*`OCS_MODE_W +: `OCS_MODE_W] == `OCS_MODE_FORCE);
      end else if (use_idle) begin
        s_d.drive[i]  = mode_level(comm_idle_output_mode[i*`OCS_MODE_W +: `OCS_MODE_W],
                                   s_q.drive[i]);
        s_d.forced[i] = (comm_idle_output_mode[i*`OCS_MODE_W +: `OCS_MODE_W] == `OCS_MODE_FORCE);
      end else begin
        s_d.drive[i]  = out_command[i];
        s_d.forced[i] = 1'b0;
      end
      // every off-to-on step of the driven output is one operation
      on_vec[i] = s_d.drive[i] && !s_q.drive[i];
    end

    // unit short error; a new short wins over an automatic clear
    if (!load_short_detect_enable) begin
      s_d.short_err = 1'b0;
    end else if (short_now) begin
      s_d.short_err = 1'b1;
    end else if (!short_error_restart_mode) begin
      s_d.short_err = 1'b0;
    end else begin
      s_d.short_err = s_q.short_err;
    end

    // open load follows the sensed condition per channel
    s_d.open_err = open_load_detect_enable & open_now;

    // save timer runs outside restore; an expiry while a save is still running is skipped, not delayed
    if (s_q.seq != OCS_SEQ_RESTORE) begin
      if (s_q.tmr >= SAVE_CYCLES - `OCS_TMR_W'(1)) begin
        s_d.tmr = '0;
      end else begin
        s_d.tmr = s_q.tmr + `OCS_TMR_W'(1);
      end
    end

    case (s_q.seq)
      OCS_SEQ_RESTORE: begin
        if (nv_rd_valid) begin
          load_vec[s_q.ch] = 1'b1;
          if (last_ch) begin
            s_d.seq = OCS_SEQ_RUN;
            s_d.ch  = '0;
          end else begin
            s_d.ch = next_ch;
          end
        end
      end
      OCS_SEQ_RUN: begin
        if (s_q.tmr >= SAVE_CYCLES - `OCS_TMR_W'(1)) begin
          s_d.seq     = OCS_SEQ_SAVE;
          s_d.ch      = '0;
          s_d.nv_data = cnt_vec[0];
        end
      end
      OCS_SEQ_SAVE: begin
        if (nv_wr_ack) begin
          if (last_ch) begin
            s_d.seq = OCS_SEQ_RUN;
            s_d.ch  = '0;
          end else begin
            s_d.ch      = next_ch;
            s_d.nv_data = cnt_vec[next_ch];
          end
        end
      end
      default: begin
        s_d.seq = OCS_SEQ_RESTORE;
        s_d.ch  = '0;
      end
    endcase
  end

  // power-up reset clears everything, including a latched short error
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '{seq:       OCS_SEQ_RESTORE,
               ch:        '0,
               tmr:       '0,
               drive:     `OCS_RST_DRIVE,
               forced:    `OCS_RST_DRIVE,
               short_err: 1'b0,
               open_err:  '0,
               nv_data:   `OCS_RST_COUNT};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // store handshakes are held levels, data and indices from flops
  assign nv_rd_req       = (s_q.seq == OCS_SEQ_RESTORE);
  assign nv_rd_ch        = s_q.ch;
  assign nv_wr_req       = (s_q.seq == OCS_SEQ_SAVE);
  assign nv_wr_ch        = s_q.ch;
  assign nv_wr_data      = s_q.nv_data;

  assign drive_out       = s_q.drive;
  assign drive_on_forced = s_q.forced;
  assign short_error     = s_q.short_err;
  assign open_error      = s_q.open_err;
  assign count_error     = err_vec;
  assign restore_done    = (s_q.seq != OCS_SEQ_RESTORE);

endmodule // ocs_supervisor

// [tb/ocs_supervisor_assertions.sv]
// concurrent checks on the output channel supervisor top ports
// assumes a bind from the bench, one clock domain and async reset
`timescale 1ns/10ps
module ocs_supervisor_assertions (
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        load_short_detect_enable,
  input wire logic        short_error_restart_mode,
  input wire logic [7:0]  open_load_detect_enable,
  input wire logic [15:0] comm_fault_output_mode,
  input wire logic [15:0] comm_idle_output_mode,
  input wire logic        handheld_priority,
  input wire logic [7:0]  counter_check_enable,
  input wire logic        comm_fault,
  input wire logic        comm_idle,
  input wire logic [7:0]  out_command,
  input wire logic        short_sense,
  input wire logic        nv_rd_req,
  input wire logic [2:0]  nv_rd_ch,
  input wire logic        nv_rd_valid,
  input wire logic        nv_wr_req,
  input wire logic [2:0]  nv_wr_ch,
  input wire logic [31:0] nv_wr_data,
  input wire logic        nv_wr_ack,
  input wire logic [7:0]  drive_out,
  input wire logic [7:0]  drive_on_forced,
  input wire logic        short_error,
  input wire logic [7:0]  open_error,
  input wire logic [7:0]  count_error,
  input wire logic        restore_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // short error: set after the two sync stages, cleared or held by restart mode
  AST_SHORT_SET: assert property ((restore_done && load_short_detect_enable && short_sense)[*3] |=> short_error)
    else $error("short error not raised");
  AST_SHORT_OFF: assert property (!load_short_detect_enable |=> !short_error)
    else $error("short error while detection off");
  AST_SHORT_AUTO: assert property ((!short_error_restart_mode && !short_sense)[*4] |=> !short_error)
    else $error("auto restart did not clear");
  AST_SHORT_MANUAL: assert property (short_error && short_error_restart_mode && load_short_detect_enable |=> short_error)
    else $error("manual short error dropped");
  // outputs follow the master unless handheld priority selects the modes
  AST_NO_HH: assert property (restore_done && !handheld_priority |=> drive_out == $past(out_command))
    else $error("output not following command");
  AST_FAULT_FORCE: assert property (restore_done && handheld_priority && comm_fault
    && comm_fault_output_mode[5:4] == 2'h2 |=> drive_out[2] && drive_on_forced[2])
    else $error("fault force on missing");
  AST_IDLE_CLEAR: assert property (restore_done && handheld_priority && comm_idle && !comm_fault
    && comm_idle_output_mode[7:6] == 2'h0 |=> !drive_out[3])
    else $error("idle clear not off");
  AST_OPEN: assert property ((open_error & ~$past(open_load_detect_enable)) == 8'h00)
    else $error("open error on disabled channel");
  AST_CNT_OFF: assert property ((!counter_check_enable[2])[*2] |=> !count_error[2])
    else $error("count error with check off");
  AST_RD_ADV: assert property (clk_en && nv_rd_req && nv_rd_valid && nv_rd_ch != 3'h7
    |=> nv_rd_ch == $past(nv_rd_ch) + 3'h1)
    else $error("restore channel did not advance");
  AST_WR_STANDS: assert property (nv_wr_req && !nv_wr_ack |=> nv_wr_req && $stable(nv_wr_ch) && $stable(nv_wr_data))
    else $error("save word not held");
  AST_HOLD_OFF: assert property (!restore_done |-> drive_out == 8'h00)
    else $error("output driven before restore");

  // main scenarios reached
  COV_SHORT: cover property ($rose(short_error));
  COV_SAVE: cover property (nv_wr_req && nv_wr_ack);
  COV_FORCE: cover property (drive_on_forced != 8'h00);
endmodule // ocs_supervisor_assertions

// [tb/ocs_nv_model.sv]
// behavioural non-volatile count store facing the supervisor
// assumes core_clk; answers each request after delay cycles, keeps data over reset
`timescale 1ns/10ps
`include "ocs_map.svh"
module ocs_nv_model (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic [1:0]            delay,
  input  wire logic                  nv_rd_req,
  input  wire logic [`OCS_CH_W-1:0]  nv_rd_ch,
  output logic                       nv_rd_valid,
  output logic      [`OCS_CNT_W-1:0] nv_rd_data,
  input  wire logic                  nv_wr_req,
  input  wire logic [`OCS_CH_W-1:0]  nv_wr_ch,
  input  wire logic [`OCS_CNT_W-1:0] nv_wr_data,
  output logic                       nv_wr_ack
);
  logic [`OCS_CNT_W-1:0] mem [`OCS_NUM_CH];
  logic [1:0]            wait_q;

  // stored counts start at 1000 plus the channel number
  initial begin
    for (int i = 0; i < `OCS_NUM_CH; i++) mem[i] = 32'h0000_03e8 + 32'(i);
    nv_rd_valid = 1'b0;
    nv_wr_ack = 1'b0;
    nv_rd_data = 32'h0000_0000;
    wait_q = 2'h0;
  end

  // one-cycle answers; idle data line toggles so a stale word never looks valid
  always @(posedge core_clk) begin
    nv_rd_valid <= 1'b0;
    nv_wr_ack <= 1'b0;
    if (!nv_rd_valid) nv_rd_data <= ~nv_rd_data;
    if (nv_wr_ack) mem[nv_wr_ch] <= nv_wr_data;
    if (reset || !(nv_rd_req || nv_wr_req) || nv_rd_valid || nv_wr_ack) wait_q <= 2'h0;
    else if (wait_q != delay) wait_q <= wait_q + 2'h1;
    else if (nv_rd_req) begin
      nv_rd_valid <= 1'b1;
      nv_rd_data <= mem[nv_rd_ch];
    end else nv_wr_ack <= 1'b1;
  end
endmodule // ocs_nv_model

// [tb/ocs_supervisor_bench.sv]
// self-checking bench for the output channel supervisor
// assumes the store model answers restore and save traffic
`timescale 1ns/10ps
`include "ocs_map.svh"
module ocs_supervisor_bench;
  logic        core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
  logic        load_short_detect_enable = 1'b0, short_error_restart_mode = 1'b0;
  logic        handheld_priority = 1'b0, comm_fault = 1'b0, comm_idle = 1'b0, short_sense = 1'b0;
  logic [7:0]  open_load_detect_enable = 8'h00, counter_check_enable = 8'h1b;
  logic [7:0]  out_command = 8'h00, open_sense = 8'h00;
  logic [15:0] comm_fault_output_mode = 16'he4e4, comm_idle_output_mode = 16'h1b1b;
  logic [127:0] counter_threshold = {16'h0001, 16'h0001, 16'h0001, 16'h0002,
                                     16'h0000, 16'h0001, 16'h0001, 16'h0001};
  logic        nv_rd_req, nv_rd_valid, nv_wr_req, nv_wr_ack, short_error, restore_done;
  logic [2:0]  nv_rd_ch, nv_wr_ch;
  logic [31:0] nv_rd_data, nv_wr_data;
  logic [7:0]  drive_out, drive_on_forced, open_error, count_error;
  logic [1:0]  delay = 2'h0;
  int          fail_count = 0, cmp_count = 0, i;

  // short save period keeps the hourly save inside the run
  ocs_supervisor #(.SAVE_CYCLES(40'hc8)) DUT (.*);
  ocs_nv_model nv (.*);

  always #25 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_restore();
    for (i = 0; i < 200 && restore_done !== 1'b1; i++) settle(1);
    settle(1);
    chk("restore_done", restore_done, 1'b1);
  endtask

  // command 77 first, then switch flags while the command drops to 00
  task automatic mode_case(input logic hh, input logic flt, input logic idl, input logic [7:0] ed, input logic [7:0] ef);
    @(posedge core_clk) {handheld_priority, comm_fault, comm_idle, out_command} <= {3'h0, 8'h77};
    settle(2);
    @(posedge core_clk) {handheld_priority, comm_fault, comm_idle, out_command} <= {hh, flt, idl, 8'h00};
    settle(2);
    chk("drive_out", drive_out, ed);
    chk("drive_on_forced", drive_on_forced, ef);
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    wait_restore();
    chk("count_error", count_error, 8'h0a);
    @(posedge core_clk) out_command <= 8'h01;
    @(posedge core_clk) out_command <= 8'h00;
    settle(3);
    chk("count_error", count_error, 8'h0b);
    $display("test restore and count done");
    // sample just after the edge that raises the request, before the first ack lands
    for (i = 0; i < 400 && nv_wr_req !== 1'b1; i++) settle(1);
    chk("nv_wr_ch", nv_wr_ch, 3'h0);
    chk("nv_wr_data", nv_wr_data, 32'h0000_03e9);
    $display("test save done");
    mode_case(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
    mode_case(1'b1, 1'b1, 1'b0, 8'h66, 8'h44);
    mode_case(1'b1, 1'b0, 1'b1, 8'h66, 8'h22);
    mode_case(1'b1, 1'b1, 1'b1, 8'h66, 8'h44);
    @(posedge core_clk) {handheld_priority, comm_fault, comm_idle} <= 3'h0;
    $display("test output modes done");
    @(posedge core_clk) {load_short_detect_enable, short_sense} <= 2'h3;
    settle(4);
    chk("short_error", short_error, 1'b1);
    @(posedge core_clk) short_sense <= 1'b0;
    settle(5);
    chk("short_error", short_error, 1'b0);
    @(posedge core_clk) {short_error_restart_mode, short_sense} <= 2'h3;
    settle(4);
    @(posedge core_clk) short_sense <= 1'b0;
    settle(10);
    chk("short_error", short_error, 1'b1);
    @(posedge core_clk) load_short_detect_enable <= 1'b0;
    settle(2);
    chk("short_error", short_error, 1'b0);
    @(posedge core_clk) short_sense <= 1'b1;
    settle(5);
    chk("short_error", short_error, 1'b0);
    @(posedge core_clk) {load_short_detect_enable, open_load_detect_enable, open_sense} <= 17'h10fff;
    settle(5);
    chk("open_error", open_error, 8'h0f);
    chk("short_error", short_error, 1'b1);
    @(posedge core_clk) {short_sense, open_sense} <= 9'h000;
    settle(5);
    chk("open_error", open_error, 8'h00);
    $display("test short and open done");
    @(posedge core_clk) {delay, reset} <= 3'h7;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    wait_restore();
    chk("short_error", short_error, 1'b0);
    chk("count_error", count_error, 8'h0b);
    $display("test power cycle done");
    close_out();
  end
endmodule // ocs_supervisor_bench

bind ocs_supervisor ocs_supervisor_assertions chk_i (.*);
